// File: bench/tsu_tx_cfg_test.sv
`timescale 1ns/1ps
module tsu_tx_cfg_test;
  import tsu_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [4:0] lkPort = 5'h00;
  logic [12:0] lkAddr = 13'h0000;
  logic lkSlotEn = 1'b0;
  logic lkExtract = 1'b0;
  logic lkData = 1'b0;
  logic [4:0] lkGroup = 5'h00;
  logic slotRun_r, slotHold_r, extractOn_r, kindOk_r;
  logic txBit_r, txBitOe_r, syncRise_r;
  logic [12:0] slotCount_r, groupFirst_r;
  logic [31:0] portOnVec_r;
  logic [5:0] groupLenM1_r;
  logic [1:0] groupState_r;
  logic [31:0] rd;
  int errors = 0;
  int nChecks = 0;

  tsu_tx_cfg dut (.ref_clk(ref_clk), .srst(srst), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lkPort(lkPort),
    .lkAddr(lkAddr), .lkSlotEn(lkSlotEn), .lkExtract(lkExtract),
    .lkData(lkData), .lkGroup(lkGroup), .slotRun_r(slotRun_r),
    .slotHold_r(slotHold_r), .slotCount_r(slotCount_r),
    .extractOn_r(extractOn_r), .kindOk_r(kindOk_r), .txBit_r(txBit_r),
    .txBitOe_r(txBitOe_r), .syncRise_r(syncRise_r),
    .portOnVec_r(portOnVec_r), .groupFirst_r(groupFirst_r),
    .groupLenM1_r(groupLenM1_r), .groupState_r(groupState_r));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic end_of_test;
    if (errors == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // entered just after an edge; ack is read before that edge's updates
  task automatic wb(input logic we, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("unexpected at %0t: ack %h exp %h", $time, wb_ack_o, 1'b1);
      end_of_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge ref_clk);
  endtask : wb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdc

  function automatic logic [11:0] ra(input logic [11:0] b, input int i);
    return b + 12'(i * 4);
  endfunction : ra

  // lookup answers one edge after the inputs land
  task automatic look(input logic [4:0] p, input logic [12:0] a,
    input logic en, input logic ex, input logic d);
    lkPort <= p;
    lkAddr <= a;
    lkSlotEn <= en;
    lkExtract <= ex;
    lkData <= d;
    repeat (2) @(posedge ref_clk);
  endtask : look

  task automatic t_regs;
    rdc(ra(OFS_ALLOC, 3), 32'h0000_0000);
    wb(1'b1, ra(OFS_ALLOC, 3), 32'hFFFF_FFFF);
    rdc(ra(OFS_ALLOC, 3), 32'h1FFF_1FFF);
    wb_sel_i <= 4'h3;
    wb(1'b1, ra(OFS_ALLOC, 3), 32'h0000_0000);
    wb_sel_i <= 4'hF;
    rdc(ra(OFS_ALLOC, 3), 32'h1FFF_0000);
    wb(1'b1, ra(OFS_GPTR, 8), 32'hFFFF_FFFF);
    rdc(ra(OFS_GPTR, 8), 32'h0007_FFFF);
    wb(1'b1, ra(OFS_PCFG, 3), 32'hFFFF_FFFF);
    rdc(ra(OFS_PCFG, 3), 32'h0000_6E3F);
    rdc(12'h204, 32'h0000_0000);
  endtask : t_regs

  task automatic t_slots;
    wb(1'b1, ra(OFS_ALLOC, 5), 32'h0014_0010);
    wb(1'b1, ra(OFS_PCFG, 5), 32'h0000_2800);
    look(5'h05, 13'h0012, 1'b1, 1'b0, 1'b0);
    chk(32'(slotRun_r), 32'h1);
    chk(32'(txBit_r), 32'h0);
    chk(32'(slotCount_r), 32'h4);
    chk(32'(slotHold_r), 32'h0);
    chk(portOnVec_r, 32'h0000_0028);
    rdc(OFS_STATUS, 32'h0001_0004);
    look(5'h05, 13'h0012, 1'b0, 1'b0, 1'b0);
    chk(32'(slotRun_r), 32'h0);
    look(5'h05, 13'h0014, 1'b1, 1'b0, 1'b0);
    chk({slotRun_r, txBit_r, txBitOe_r}, 32'h3);
    wb(1'b1, ra(OFS_PCFG, 5), 32'h0000_2802);
    look(5'h05, 13'h0014, 1'b1, 1'b0, 1'b0);
    chk(32'(txBitOe_r), 32'h0);
    wb(1'b1, ra(OFS_PCFG, 5), 32'h0000_0800);
    look(5'h05, 13'h0012, 1'b1, 1'b0, 1'b0);
    chk({slotHold_r, slotRun_r, portOnVec_r[5]}, 32'h4);
    rdc(ra(OFS_ALLOC, 5), 32'h0014_0010);
  endtask : t_slots

  task automatic t_unch;
    wb(1'b1, ra(OFS_ALLOC, 9), 32'h0005_0020);
    wb(1'b1, ra(OFS_PCFG, 9), 32'h0000_2000);
    look(5'h09, 13'h0020, 1'b1, 1'b0, 1'b1);
    chk({slotRun_r, txBit_r}, 32'h3);
    look(5'h09, 13'h0021, 1'b1, 1'b0, 1'b0);
    chk(32'(slotRun_r), 32'h0);
    look(5'h09, 13'h0005, 1'b1, 1'b0, 1'b0);
    chk(32'(slotRun_r), 32'h0);
  endtask : t_unch

  // port kind against slot count, both sides of each limit; kinds 2 and 3 only at their matching count
  task automatic t_kinds;
    logic [2:0] kd [13] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5, 6, 6, 7};
    logic [12:0] cn [13] = '{0, 1, 24, 23, 2, 3, 4, 5, 5, 4, 9, 7, 24};
    logic ok [13] = '{1, 0, 1, 0, 1, 1, 1, 0, 1, 0, 1, 0, 0};
    for (int i = 0; i < 13; i++) begin
      wb(1'b1, ra(OFS_ALLOC, 7), {3'h0, cn[i], 16'h0000});
      wb(1'b1, ra(OFS_PCFG, 7), {20'h0, kd[i], 9'h000});
      look(5'h07, 13'h0000, 1'b0, 1'b0, 1'b0);
      chk(32'(kindOk_r), 32'(ok[i]));
    end
  endtask : t_kinds

  task automatic t_extract;
    wb(1'b1, ra(OFS_ALLOC, 11), 32'h000A_0000);
    wb(1'b1, ra(OFS_PCFG, 11), 32'h0000_6C00);
    wb(1'b1, ra(OFS_ALLOC, 12), 32'h000A_0000);
    wb(1'b1, ra(OFS_PCFG, 12), 32'h0000_2C00);
    look(5'h0B, 13'h0003, 1'b0, 1'b1, 1'b1);
    chk({extractOn_r, syncRise_r}, 32'h3);
    look(5'h0B, 13'h0003, 1'b0, 1'b0, 1'b1);
    chk(32'(extractOn_r), 32'h0);
    look(5'h0C, 13'h0003, 1'b0, 1'b1, 1'b1);
    chk(32'(extractOn_r), 32'h0);
  endtask : t_extract

  task automatic t_group;
    wb(1'b1, ra(OFS_GPTR, 4), 32'h0000_48EA);
    wb(1'b1, ra(OFS_GSTATE, 4), 32'h0000_0000);
    rdc(ra(OFS_GSTATE, 4), 32'h0000_0000);
    wb(1'b1, ra(OFS_GSTATE, 4), 32'h0000_0001);
    wb(1'b1, ra(OFS_GSTATE, 4), 32'h0000_0003);
    lkGroup <= 5'h04;
    look(5'h00, 13'h0000, 1'b0, 1'b0, 1'b0);
    chk(32'(groupFirst_r), 32'h123);
    chk(32'(groupLenM1_r), 32'h2A);
    chk(32'(groupState_r), 32'h1);
    wb(1'b1, ra(OFS_GSTATE, 4), 32'h0000_0002);
    rdc(ra(OFS_GSTATE, 4), 32'h0000_0002);
  endtask : t_group

  // low clock enable must freeze the lookup outputs
  task automatic t_freeze;
    look(5'h0B, 13'h0003, 1'b1, 1'b0, 1'b1);
    chk({slotRun_r, slotHold_r, txBit_r}, 32'h5);
    ce <= 1'b0;
    look(5'h05, 13'h0012, 1'b1, 1'b0, 1'b0);
    chk({slotRun_r, slotHold_r, txBit_r}, 32'h5);
    ce <= 1'b1;
    look(5'h05, 13'h0012, 1'b1, 1'b0, 1'b0);
    chk({slotRun_r, slotHold_r, txBit_r}, 32'h3);
  endtask : t_freeze

  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_slots();
    t_unch();
    t_kinds();
    t_extract();
    t_group();
    t_freeze();
    end_of_test();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
endmodule : tsu_tx_cfg_test

// File: verilog/tsu_eval_if.sv
`timescale 1ns/1ps
interface tsu_eval_if;
  import tsu_pkg::*;
  tsu_kind_t kind;
  logic portOn;
  logic floatSel;
  logic [12:0] first;
  logic [12:0] last;
  logic [4:0] portIdx;
  logic [12:0] slotAddr;
  logic slotEnable;
  logic extract;
  logic slotData;
  logic [12:0] count;
  logic mapped;
  logic run;
  logic hold;
  logic extractOk;
  logic kindOk;
  logic txBit;
  logic txOe;
  modport cfg (output kind, portOn, floatSel, first, last, portIdx,
    slotAddr, slotEnable, extract, slotData,
    input count, mapped, run, hold, extractOk, kindOk, txBit, txOe);
  modport eval (input kind, portOn, floatSel, first, last, portIdx,
    slotAddr, slotEnable, extract, slotData,
    output count, mapped, run, hold, extractOk, kindOk, txBit, txOe);
endinterface : tsu_eval_if

// File: verilog/tsu_pkg.sv
package tsu_pkg;
  localparam int NPORT = 32;
  localparam int NGROUP = 32;
  localparam int PTR_W = 13;
  localparam int IDX_W = 5;
  localparam int ADR_W = 12;

  // word-aligned byte offsets of the register banks
  localparam logic [11:0] OFS_ALLOC = 12'h000;
  localparam logic [11:0] OFS_GPTR = 12'h080;
  localparam logic [11:0] OFS_GSTATE = 12'h100;
  localparam logic [11:0] OFS_PCFG = 12'h180;
  localparam logic [11:0] OFS_STATUS = 12'h200;
  localparam int BANK_LSB = 7;
  localparam int IDX_LSB = 2;

  // field positions
  localparam int ALLOC_LAST_LSB = 16;
  localparam int ALLOC_FIRST_LSB = 0;
  localparam int GRP_FIRST_LSB = 6;
  localparam int GRP_LEN_LSB = 0;
  localparam int GRP_LEN_W = 6;
  localparam int GSTATE_LSB = 0;
  localparam int CFG_SYNC_BIT = 14;
  localparam int CFG_ON_BIT = 13;
  localparam int CFG_KIND_LSB = 9;
  localparam int CFG_FLOAT_BIT = 1;
  localparam int STAT_KINDOK_BIT = 16;
  localparam int STAT_EXTR_BIT = 17;

  // writable bits; everything else reads as zero
  localparam logic [31:0] ALLOC_MASK = 32'h1FFF_1FFF;
  localparam logic [31:0] GPTR_MASK = 32'h0007_FFFF;
  localparam logic [31:0] GSTATE_MASK = 32'h0000_0003;
  localparam logic [31:0] PCFG_MASK = 32'h0000_6E3F;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // slot-count limits tied to the port kinds, and the number of extraction ports
  localparam logic [12:0] T1_SLOTS = 13'h0018;
  localparam logic [12:0] NX_MIN = 13'h0004;
  localparam logic [12:0] BUS_MIN = 13'h0008;
  localparam logic [4:0] EXTRACT_PORTS = 5'h0C;

  typedef enum logic [2:0] {
    KIND_UNCH = 3'h0,
    KIND_T1 = 3'h1,
    KIND_N2 = 3'h2,
    KIND_N3 = 3'h3,
    KIND_N4 = 3'h4,
    KIND_NX = 3'h5,
    KIND_BUS = 3'h6,
    KIND_RSV = 3'h7
  } tsu_kind_t;

  typedef enum logic [1:0] {
    GS_OFF = 2'h0,
    GS_ON = 2'h1,
    GS_POLL = 2'h2,
    GS_RSV = 2'h3
  } tsu_gstate_t;
endpackage : tsu_pkg

// File: verilog/tsu_slot_eval.sv
`timescale 1ns/1ps
module tsu_slot_eval
  import tsu_pkg::*;
(
  tsu_eval_if.eval ev
);
  wire unch = (ev.kind == KIND_UNCH);
  wire inRange = (ev.slotAddr >= ev.first) && (ev.slotAddr < ev.last);
  wire slotGo = ev.slotEnable | ev.extractOk;

  assign ev.count = 13'(ev.last - ev.first);
  // unchannelized ports own only the first entry; last is free
  assign ev.mapped = unch ? (ev.slotAddr == ev.first) : inRange;
  assign ev.extractOk = (ev.kind == KIND_BUS) && ev.extract &&
    (ev.portIdx < EXTRACT_PORTS);
  assign ev.hold = ~ev.portOn;
  assign ev.run = ev.portOn & ev.mapped & slotGo;
  // idle slots send ones unless the float select is set
  assign ev.txBit = ev.run ? ev.slotData : 1'b1;
  assign ev.txOe = ev.run | ~ev.floatSel;

  // software is expected to match kind and slot count
  always_comb begin
    case (ev.kind)
      KIND_UNCH: ev.kindOk = (ev.count == 13'h0000);
      KIND_T1: ev.kindOk = (ev.count == T1_SLOTS);
      KIND_N2: ev.kindOk = (ev.count == 13'h0002);
      KIND_N3: ev.kindOk = (ev.count == 13'h0003);
      KIND_N4: ev.kindOk = (ev.count == 13'h0004);
      KIND_NX: ev.kindOk = (ev.count > NX_MIN);
      KIND_BUS: ev.kindOk = (ev.count > BUS_MIN);
      default: ev.kindOk = 1'b0;
    endcase
  end
endmodule : tsu_slot_eval

// File: verilog/tsu_tx_cfg.sv
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
// What this block does
// - per port, one allocation word; slot count is last minus first
// - kind zero uses only the first entry; last pointer only sets the slot count, which its kind check needs at zero
// - allocation word: last in 28:16, first in 12:0, rest zero
// - group pointer: first location in 18:6, count minus one in 5:0
// - group state 0 off, 1 on, 2 polling, 3 reserved
// - port enable bit 13 clear holds every slot in reset
// - with port enabled a slot runs only if its own enable is set or extraction is granted
// - kind field 11:9; code 1 is T1 with 24 slots; 7 reserved
// - kind 6 on first twelve ports allows per-slot channel extraction
// - enabled port, unmapped slot: drive one, or float if selected
module tsu_tx_cfg
  import tsu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [4:0] lkPort,
  input wire logic [12:0] lkAddr,
  input wire logic lkSlotEn,
  input wire logic lkExtract,
  input wire logic lkData,
  input wire logic [4:0] lkGroup,
  output logic slotRun_r,
  output logic slotHold_r,
  output logic [12:0] slotCount_r,
  output logic extractOn_r,
  output logic kindOk_r,
  output logic txBit_r,
  output logic txBitOe_r,
  output logic syncRise_r,
  output logic [31:0] portOnVec_r,
  output logic [12:0] groupFirst_r,
  output logic [5:0] groupLenM1_r,
  output logic [1:0] groupState_r
);
  logic [31:0] allocMem [NPORT];
  logic [31:0] gptrMem [NGROUP];
  logic [1:0] gstateMem [NGROUP];
  logic [31:0] pcfgMem [NPORT];
  logic [31:0] datR;
  logic ackR;

  // bus decode
  wire req = wb_cyc_i & wb_stb_i & ~ackR;
  wire [4:0] idx = wb_adr_i[6:IDX_LSB];
  wire [4:0] bank = wb_adr_i[11:BANK_LSB];
  wire hitAlloc = (bank == OFS_ALLOC[11:BANK_LSB]);
  wire hitGptr = (bank == OFS_GPTR[11:BANK_LSB]);
  wire hitGstate = (bank == OFS_GSTATE[11:BANK_LSB]);
  wire hitPcfg = (bank == OFS_PCFG[11:BANK_LSB]);
  wire hitStatus = (wb_adr_i[11:IDX_LSB] == OFS_STATUS[11:IDX_LSB]);
  // writes land on the ack edge, while the master still holds the request
  wire doWrite = wb_cyc_i & wb_stb_i & wb_we_i & ackR & ce;
  wire [31:0] byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [31:0] be, input logic [31:0] keep);
    merge = ((old & ~be) | (nw & be)) & keep;
  endfunction : merge

  wire [31:0] allocNxt = merge(allocMem[idx], wb_dat_i, byteMask,
    ALLOC_MASK);
  wire [31:0] gptrNxt = merge(gptrMem[idx], wb_dat_i, byteMask,
    GPTR_MASK);
  wire [31:0] gstateNxt = merge({30'h0, gstateMem[idx]}, wb_dat_i,
    byteMask, GSTATE_MASK);
  wire [31:0] pcfgNxt = merge(pcfgMem[idx], wb_dat_i, byteMask, PCFG_MASK);
  // the reserved state code is never stored, so it can never be read
  wire gstateLegal = (gstateNxt[1:0] != GS_RSV);

  wire [31:0] statusWord = {14'h0, extractOn_r, kindOk_r, 3'h0,
    slotCount_r};
  // unmapped addresses still answer, with zero data
  wire [31:0] rdData = hitAlloc ? allocMem[idx] :
    hitGptr ? gptrMem[idx] :
    hitGstate ? {30'h0, gstateMem[idx]} :
    hitPcfg ? pcfgMem[idx] :
    hitStatus ? statusWord : 32'h0000_0000;

  // registered ack: one wait state, read data stands with it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ackR <= 1'b0;
      datR <= REG_RESET;
    end else if (ce) begin
      ackR <= req;
      if (req) begin
        datR <= rdData;
      end
    end
  end

  assign wb_ack_o = ackR;
  assign wb_dat_o = datR;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < NPORT; i++) begin
        allocMem[i] <= REG_RESET;
        pcfgMem[i] <= REG_RESET;
        gptrMem[i] <= REG_RESET;
        gstateMem[i] <= GS_OFF;
      end
    end else if (doWrite) begin
      if (hitAlloc) begin
        allocMem[idx] <= allocNxt;
      end
      if (hitGptr) begin
        gptrMem[idx] <= gptrNxt;
      end
      if (hitGstate && gstateLegal) begin
        gstateMem[idx] <= gstateNxt[1:0];
      end
      if (hitPcfg) begin
        pcfgMem[idx] <= pcfgNxt;
      end
    end
  end

  // per-port enable vector, one flip-flop per port
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_on
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          portOnVec_r[gp] <= 1'b0;
        end else if (ce) begin
          portOnVec_r[gp] <= pcfgMem[gp][CFG_ON_BIT];
        end
      end
    end
  endgenerate

  // slot evaluation for the looked-up port
  tsu_eval_if ev ();
  wire [31:0] selAlloc = allocMem[lkPort];
  wire [31:0] selCfg = pcfgMem[lkPort];
  assign ev.kind = tsu_kind_t'(selCfg[CFG_KIND_LSB +: 3]);
  assign ev.portOn = selCfg[CFG_ON_BIT];
  assign ev.floatSel = selCfg[CFG_FLOAT_BIT];
  assign ev.first = selAlloc[ALLOC_FIRST_LSB +: PTR_W];
  assign ev.last = selAlloc[ALLOC_LAST_LSB +: PTR_W];
  assign ev.portIdx = lkPort;
  assign ev.slotAddr = lkAddr;
  assign ev.slotEnable = lkSlotEn;
  assign ev.extract = lkExtract;
  assign ev.slotData = lkData;

  tsu_slot_eval u_eval (
    .ev(ev.eval)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      slotRun_r <= 1'b0;
      slotHold_r <= 1'b1;
      slotCount_r <= 13'h0000;
      extractOn_r <= 1'b0;
      kindOk_r <= 1'b0;
      txBit_r <= 1'b1;
      txBitOe_r <= 1'b0;
      syncRise_r <= 1'b0;
    end else if (ce) begin
      slotRun_r <= ev.run;
      slotHold_r <= ev.hold;
      slotCount_r <= ev.count;
      extractOn_r <= ev.extractOk;
      kindOk_r <= ev.kindOk;
      txBit_r <= ev.txBit;
      txBitOe_r <= ev.txOe;
      syncRise_r <= selCfg[CFG_SYNC_BIT];
    end
  end

  // group pointer and state lookup
  wire [31:0] selGptr = gptrMem[lkGroup];
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      groupFirst_r <= 13'h0000;
      groupLenM1_r <= 6'h00;
      groupState_r <= GS_OFF;
    end else if (ce) begin
      groupFirst_r <= selGptr[GRP_FIRST_LSB +: PTR_W];
      groupLenM1_r <= selGptr[GRP_LEN_LSB +: GRP_LEN_W];
      groupState_r <= gstateMem[lkGroup];
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_ack_single_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (ce && req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_alloc_rsvd_zero: assert property (
    wb_ack_o && $past(hitAlloc && !wb_we_i) |->
    (wb_dat_o & ~ALLOC_MASK) == 32'h0)
    else $error("alloc word reserved bits not zero");
  a_gptr_rsvd_zero: assert property (
    wb_ack_o && $past(hitGptr && !wb_we_i) |->
    (wb_dat_o & ~GPTR_MASK) == 32'h0)
    else $error("group pointer reserved bits not zero");
  a_gstate_no_rsvd: assert property (groupState_r != GS_RSV)
    else $error("reserved group state observed");
  a_port_off_hold: assert property (
    ce && !ev.portOn |=> slotHold_r && !slotRun_r && txBit_r)
    else $error("disabled port slot not held");
  a_slot_and_run: assert property (
    ce && ev.portOn && ev.mapped && lkSlotEn |=> slotRun_r)
    else $error("enabled slot did not run");
  a_unch_first_only: assert property (
    ce && ev.kind == KIND_UNCH && lkAddr != ev.first |=> !slotRun_r)
    else $error("unchannelized port used another entry");
  a_count_diff: assert property (
    ce |=> slotCount_r == 13'($past(ev.last) - $past(ev.first)))
    else $error("slot count not last minus first");
  a_extract_ports: assert property (
    ce && lkPort >= EXTRACT_PORTS |=> !extractOn_r)
    else $error("extraction on a port above the first twelve");
  a_unmapped_drive: assert property (
    ce && ev.portOn && !ev.mapped |=>
    txBit_r && (txBitOe_r == !$past(ev.floatSel)))
    else $error("unmapped slot output wrong");
  a_t1_count: assert property (
    ce && ev.kind == KIND_T1 && ev.count != T1_SLOTS |=> !kindOk_r)
    else $error("T1 kind accepted with wrong count");
  a_ack_from_req: assert property (
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  // srst still acts while ce is low; only ordinary updates freeze
  a_freeze_state: assert property (!ce |=> $stable(slotRun_r) &&
    $stable(slotHold_r) && $stable(txBit_r) && $stable(txBitOe_r) &&
    $stable(portOnVec_r) && $stable(wb_ack_o) && $stable(wb_dat_o))
    else $error("state moved while clock enable low");

  // read-back checks: reserved bits and decode holes read zero
  a_pcfg_rsvd_zero: assert property (
    wb_ack_o && $past(hitPcfg && !wb_we_i) |->
    (wb_dat_o & ~PCFG_MASK) == 32'h0)
    else $error("port config reserved bits not zero");
  a_gstate_read: assert property (
    wb_ack_o && $past(hitGstate && !wb_we_i) |->
    wb_dat_o[31:2] == 30'h0 && wb_dat_o[1:0] != GS_RSV)
    else $error("group state read back out of range");
  a_status_read: assert property (
    wb_ack_o && $past(hitStatus && !wb_we_i) |->
    wb_dat_o[12:0] == $past(slotCount_r) && wb_dat_o[31:18] == 14'h0)
    else $error("status word wrong");
  a_unmapped_zero: assert property (
    wb_ack_o && $past(!(hitAlloc || hitGptr || hitGstate || hitPcfg ||
    hitStatus)) |-> wb_dat_o == 32'h0)
    else $error("unmapped address read not zero");

  // lookup checks, one ce edge after the inputs
  a_hold_follows: assert property (
    ce |=> slotHold_r == !$past(ev.portOn))
    else $error("hold does not follow port enable");
  a_slot_off_idle: assert property (
    ce && !lkSlotEn && !ev.extractOk |=> !slotRun_r)
    else $error("slot ran without its enable");
  a_run_data: assert property (
    ce && ev.run |=> txBit_r == $past(lkData) && txBitOe_r)
    else $error("running slot did not send its data");
  a_unch_any_last: assert property (
    ce && ev.portOn && ev.kind == KIND_UNCH && lkAddr == ev.first &&
    lkSlotEn |=> slotRun_r)
    else $error("unchannelized first entry did not run");
  a_rsvd_kind_bad: assert property (
    ce && ev.kind == KIND_RSV |=> !kindOk_r)
    else $error("reserved port kind accepted");
  a_extract_kind: assert property (
    ce && ev.kind != KIND_BUS |=> !extractOn_r)
    else $error("extraction outside strobed bus mode");
  a_group_fields: assert property (
    ce |=> {groupFirst_r, groupLenM1_r} == $past(gptrMem[lkGroup][18:0]))
    else $error("group pointer fields wrong");
  a_sync_follows: assert property (
    ce |=> syncRise_r == $past(selCfg[CFG_SYNC_BIT]))
    else $error("sync edge select not passed through");

  c_write: cover property (req && wb_we_i && hitPcfg ##1 doWrite);
  c_run: cover property (slotRun_r ##1 slotRun_r);
  c_float: cover property (!slotHold_r && !txBitOe_r);
  c_extract: cover property (extractOn_r && slotRun_r);
  c_freeze: cover property (!ce ##1 !ce ##1 slotRun_r);
endmodule : tsu_tx_cfg
